// ===== hw/gcc_gain_ctrl.sv
// Receive gain and transmit attenuation code control with serial register port
`timescale 1ns/1ns
`include "gcc_consts.svh"

// Operation
// - Accept 6-bit receive gain code, -12..+48 dB
// - Lookup spreads receive gain over three stages
// - Receive gain resets to minimum -12 dB
// - Receive gain loads from nibble, port, serial
// - Receive gain register 0x09, bit 6 enables
// - Nibble gain loading only in full duplex
// - Strobe high, sync low: capture on edge
// - Strobe low routes nibbles to filter path
// - Register 0x0B bit 3 is software strobe
// - Bit 2 enables nibble gain, full-duplex default
// - Gain port loads selected register continuously
// - Bits 5/6 select receive/transmit port destination
// - Three-bit code taken from top port lines
// - Three-bit map: -12, -12, then 8 dB steps
// - Bit 1 enables three-bit map in half duplex only, pin defaults
// - Transmit code sets converter and line attenuation
// - Converter-only output uses four code LSBs
// - Transmit gain register 0x0A, bit 6 enables
// - Transmit gain resets to 0 dBFS, port off
// - Mode pin high full duplex, low half
module gcc_gain_ctrl #(
   parameter int NIB_HALF = `GCC_NIB_HALF_DEF
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                mode_full_duplex,
   input  wire logic                config_pin,
   input  wire logic                nib_clk_falling,
   input  wire gcc_pkg::gcc_serial_in_t serial_in,
   output logic                     sdio_out,
   output logic                     sdio_oe,
   input  wire logic [5:0]          gain_port_bus,
   input  wire logic                gain_strobe,
   input  wire logic                tx_word_sync,
   input  wire logic [5:0]          tx_nibble,
   output logic                     nibble_clock_out,
   output logic [5:0]               filt_nibble,
   output logic                     filt_valid,
   output gcc_pkg::gcc_rx_stages_t  receive_gain_amp,
   output gcc_pkg::gcc_tx_att_t     transmit_attenuator,
   output logic [5:0]               rx_gain_code,
   output logic [5:0]               tx_gain_code
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------

   // Gain code to three amplifier stages
   function automatic gcc_pkg::gcc_rx_stages_t rx_lut(input logic [5:0] code);
      logic [5:0]             g;
      logic [5:0]             rem;
      gcc_pkg::gcc_rx_stages_t s;
      g = (code > `GCC_RX_GAIN_MAX) ? `GCC_RX_GAIN_MAX : code;
      if (g >= 6'd60)
      begin
         s.coarse = 3'd5;
         rem      = g - 6'd60;
      end
      else if (g >= 6'd48)
      begin
         s.coarse = 3'd4;
         rem      = g - 6'd48;
      end
      else if (g >= 6'd36)
      begin
         s.coarse = 3'd3;
         rem      = g - 6'd36;
      end
      else if (g >= 6'd24)
      begin
         s.coarse = 3'd2;
         rem      = g - 6'd24;
      end
      else if (g >= 6'd12)
      begin
         s.coarse = 3'd1;
         rem      = g - 6'd12;
      end
      else
      begin
         s.coarse = 3'd0;
         rem      = g;
      end
      s.mid  = (rem >= 6'd6);
      s.fine = s.mid ? 3'(rem - 6'd6) : rem[2:0];
      return s;
   endfunction : rx_lut

   // Receive code held inside the top gain step
   function automatic logic [5:0] rx_clamp(input logic [5:0] code);
      return (code > `GCC_RX_GAIN_MAX) ? `GCC_RX_GAIN_MAX : code;
   endfunction : rx_clamp

   // Three-bit legacy code to six-bit gain code
   function automatic logic [5:0] map3(input logic [2:0] c);
      logic [5:0] v;
      v = 6'h00;
      if (c > 3'd1)
      begin
         v = 6'(({3'h0, c} - 6'd1) * `GCC_MAP3_STEP);
      end
      return v;
   endfunction : map3

   // Transmit code to converter and line attenuation
   function automatic gcc_pkg::gcc_tx_att_t tx_map(input logic [5:0] code,
                                                   input logic       conv_only);
      gcc_pkg::gcc_tx_att_t a;
      if (conv_only)
      begin
         a.conv_att    = code[3:0];
         a.line_att    = 6'h00;
         a.line_amp_en = 1'b0;
      end
      else
      begin
         a.conv_att    = 4'h0;
         a.line_att    = (code > `GCC_LINE_ATT_MAX) ? `GCC_LINE_ATT_MAX : code;
         a.line_amp_en = 1'b1;
      end
      return a;
   endfunction : tx_map

   // Register read mux
   function automatic logic [7:0] reg_read(input logic [6:0]          addr,
                                           input gcc_pkg::gcc_state_t st);
      logic [7:0] v;
      v = 8'h00;
      if (addr == `GCC_RX_GAIN_OFS)
      begin
         if (st.rx_en)
         begin
            v = {1'b0, st.rx_en, st.rx_code};
         end
      end
      else if (addr == `GCC_TX_GAIN_OFS)
      begin
         if (st.tx_en)
         begin
            v = {1'b0, st.tx_en, st.tx_code};
         end
      end
      else if (addr == `GCC_SRC_SEL_OFS)
      begin
         v = st.sel;
      end
      else if (addr == `GCC_TX_PATH_OFS)
      begin
         v = st.path;
      end
      return v;
   endfunction : reg_read

   // ----------------------------------------
   // State
   // ----------------------------------------
   gcc_pkg::gcc_state_t s_q;
   gcc_pkg::gcc_state_t s_d;

   logic       sclk_rise;
   logic       sclk_fall;
   logic       div_tick;
   logic       nib_edge;
   logic       strobe_eff;
   logic       nib_load;
   logic       wr_done;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic [5:0] port_code;

   always_comb
   begin
      s_d       = s_q;
      sclk_rise = serial_in.sclk & ~s_q.sclk_prev;
      sclk_fall = ~serial_in.sclk & s_q.sclk_prev;
      wr_done   = 1'b0;
      wr_addr   = s_q.shift[13:7];
      wr_data   = {s_q.shift[6:0], serial_in.sdio_in};

      // ----------------------------------------
      // Mode-dependent defaults after reset
      // ----------------------------------------
      if (s_q.init)
      begin
         s_d.init                       = 1'b0;
         s_d.sel[`GCC_NIB_GAIN_BIT]     = mode_full_duplex;
         s_d.sel[`GCC_SEL_RX_BIT]       = ~mode_full_duplex;
         s_d.sel[`GCC_MAP3_BIT]         = ~mode_full_duplex & config_pin;
      end

      // ----------------------------------------
      // Serial port slave
      // ----------------------------------------
      s_d.sclk_prev = serial_in.sclk;
      case (s_q.sp)
         gcc_pkg::SP_IDLE:
         begin
            s_d.sdo_oe  = 1'b0;
            s_d.bit_cnt = 5'h00;
            if (!serial_in.sen_n)
            begin
               s_d.sp = gcc_pkg::SP_SHIFT;
            end
         end
         gcc_pkg::SP_SHIFT:
         begin
            if (serial_in.sen_n)
            begin
               s_d.sp     = gcc_pkg::SP_IDLE;
               s_d.sdo_oe = 1'b0;
            end
            else if (sclk_rise)
            begin
               s_d.shift   = {s_q.shift[14:0], serial_in.sdio_in};
               s_d.bit_cnt = s_q.bit_cnt + 5'h01;
               if (s_q.bit_cnt == `GCC_HDR_BITS - 5'h01 && s_q.shift[6])
               begin
                  s_d.rd_data = reg_read({s_q.shift[5:0], serial_in.sdio_in}, s_q);
                  s_d.sdo_oe  = 1'b1;
                  s_d.sdo     = s_d.rd_data[7];
               end
               if (s_q.bit_cnt == `GCC_FRAME_BITS - 5'h01)
               begin
                  s_d.sp  = gcc_pkg::SP_IDLE;
                  wr_done = ~s_q.shift[14];
               end
            end
            else if (sclk_fall && s_q.sdo_oe && s_q.bit_cnt > `GCC_HDR_BITS)
            begin
               s_d.rd_data = {s_q.rd_data[6:0], 1'b0};
               s_d.sdo     = s_q.rd_data[6];
            end
         end
         default:
         begin
            s_d.sp = gcc_pkg::SP_IDLE;
         end
      endcase

      // ----------------------------------------
      // Nibble clock divider and edge select
      // ----------------------------------------
      div_tick = (s_q.div_cnt == 8'(NIB_HALF - 1));
      s_d.div_cnt = div_tick ? 8'h00 : s_q.div_cnt + 8'h01;
      if (div_tick)
      begin
         s_d.nclk = ~s_q.nclk;
      end
      nib_edge = div_tick & (nib_clk_falling ? s_q.nclk : ~s_q.nclk);

      // ----------------------------------------
      // Nibble bus: gain capture or filter data
      // ----------------------------------------
      strobe_eff = gain_strobe | s_q.sel[`GCC_SW_STROBE_BIT];
      nib_load   = nib_edge & strobe_eff & ~tx_word_sync
                 & mode_full_duplex & s_q.sel[`GCC_NIB_GAIN_BIT];
      s_d.filt_valid = 1'b0;
      if (nib_edge && !strobe_eff)
      begin
         s_d.filt_nib   = tx_nibble;
         s_d.filt_valid = 1'b1;
      end

      // ----------------------------------------
      // Gain register sources, serial wins
      // ----------------------------------------
      port_code = s_q.sel[`GCC_MAP3_BIT] && !mode_full_duplex
                ? map3(gain_port_bus[5:3])
                : gain_port_bus;
      if (s_q.sel[`GCC_SEL_RX_BIT])
      begin
         s_d.rx_code = rx_clamp(port_code);
      end
      if (s_q.sel[`GCC_SEL_TX_BIT])
      begin
         s_d.tx_code = gain_port_bus;
      end
      if (nib_load)
      begin
         s_d.rx_code = rx_clamp(tx_nibble);
      end
      if (wr_done)
      begin
         if (wr_addr == `GCC_RX_GAIN_OFS)
         begin
            s_d.rx_en = wr_data[`GCC_UPD_EN_BIT];
            if (wr_data[`GCC_UPD_EN_BIT])
            begin
               s_d.rx_code = rx_clamp(wr_data[5:0]);
            end
         end
         else if (wr_addr == `GCC_TX_GAIN_OFS)
         begin
            s_d.tx_en = wr_data[`GCC_UPD_EN_BIT];
            if (wr_data[`GCC_UPD_EN_BIT])
            begin
               s_d.tx_code = wr_data[5:0];
            end
         end
         else if (wr_addr == `GCC_SRC_SEL_OFS)
         begin
            s_d.sel  = wr_data & 8'h6e;
            s_d.init = 1'b0;
         end
         else if (wr_addr == `GCC_TX_PATH_OFS)
         begin
            s_d.path = wr_data & 8'h01;
         end
      end

      // ----------------------------------------
      // Gain outputs from the stored codes
      // ----------------------------------------
      s_d.rx_stages = rx_lut(s_q.rx_code);
      s_d.tx_att    = tx_map(s_q.tx_code, s_q.path[`GCC_CONV_ONLY_BIT]);

      // ----------------------------------------
      // Synchronous reset
      // ----------------------------------------
      if (!rst_n)
      begin
         s_d            = '0;
         s_d.sp         = gcc_pkg::SP_IDLE;
         s_d.rx_code    = `GCC_RX_GAIN_RST;
         s_d.tx_code    = `GCC_TX_GAIN_RST;
         s_d.init       = 1'b1;
         s_d.rx_stages  = rx_lut(`GCC_RX_GAIN_RST);
         s_d.tx_att     = tx_map(`GCC_TX_GAIN_RST, 1'b0);
      end
   end

   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign sdio_out            = s_q.sdo;
   assign sdio_oe             = s_q.sdo_oe;
   assign nibble_clock_out    = s_q.nclk;
   assign filt_nibble         = s_q.filt_nib;
   assign filt_valid          = s_q.filt_valid;
   assign receive_gain_amp    = s_q.rx_stages;
   assign transmit_attenuator = s_q.tx_att;
   assign rx_gain_code        = s_q.rx_code;
   assign tx_gain_code        = s_q.tx_code;

endmodule : gcc_gain_ctrl

// ===== hw/gcc_consts.svh
// Offsets, field positions and reset values of the gain-code control block
`ifndef GCC_CONSTS_SVH
`define GCC_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GCC_RX_GAIN_OFS     7'h09
`define GCC_TX_GAIN_OFS     7'h0a
`define GCC_SRC_SEL_OFS     7'h0b
`define GCC_TX_PATH_OFS     7'h0e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GCC_UPD_EN_BIT      6
`define GCC_SEL_TX_BIT      6
`define GCC_SEL_RX_BIT      5
`define GCC_SW_STROBE_BIT   3
`define GCC_NIB_GAIN_BIT    2
`define GCC_MAP3_BIT        1
`define GCC_CONV_ONLY_BIT   0

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define GCC_RX_GAIN_RST     6'h00
`define GCC_TX_GAIN_RST     6'h00
`define GCC_RX_GAIN_MAX     6'h3c
`define GCC_CONV_ATT_MAX    6'h0f
`define GCC_LINE_ATT_MAX    6'h27
`define GCC_MAP3_STEP       6'h08
`define GCC_FRAME_BITS      5'h10
`define GCC_HDR_BITS        5'h08
`define GCC_NIB_HALF_DEF    8

`endif

// ===== hw/gcc_pkg.sv
// Types shared by the gain-code control block
package gcc_pkg;

   // Serial port states
   typedef enum logic [1:0] {
      SP_IDLE  = 2'b01,
      SP_SHIFT = 2'b10
   } gcc_sp_state_t;

   // Receive gain split over three amplifier stages
   typedef struct packed {
      logic [2:0] coarse;   // 12 dB steps
      logic       mid;      // 6 dB step
      logic [2:0] fine;     // 1 dB steps
   } gcc_rx_stages_t;

   // Transmit attenuation controls, half-dB units
   typedef struct packed {
      logic [3:0] conv_att;
      logic [5:0] line_att;
      logic       line_amp_en;
   } gcc_tx_att_t;

   // Serial pin group
   typedef struct packed {
      logic sen_n;
      logic sclk;
      logic sdio_in;
   } gcc_serial_in_t;

   // Full state of the block
   typedef struct packed {
      gcc_sp_state_t  sp;
      logic [5:0]     rx_code;
      logic           rx_en;
      logic [5:0]     tx_code;
      logic           tx_en;
      logic [7:0]     sel;
      logic [7:0]     path;
      logic           init;
      logic [7:0]     div_cnt;
      logic           nclk;
      logic [15:0]    shift;
      logic [4:0]     bit_cnt;
      logic           sclk_prev;
      logic [7:0]     rd_data;
      logic           sdo;
      logic           sdo_oe;
      logic [5:0]     filt_nib;
      logic           filt_valid;
      gcc_rx_stages_t rx_stages;
      gcc_tx_att_t    tx_att;
   } gcc_state_t;

endpackage : gcc_pkg

// ===== test/gcc_gain_ctrl_checker.sv
// Assertion checker for the gain-code control block
`timescale 1ns/1ns
module gcc_gain_ctrl_checker (
   input wire logic                    clk,
   input wire logic                    rst_n,
   input wire logic                    mode_full_duplex,
   input wire gcc_pkg::gcc_serial_in_t serial_in,
   input wire logic                    sdio_oe,
   input wire logic [5:0]              gain_port_bus,
   input wire logic                    gain_strobe,
   input wire logic [5:0]              tx_nibble,
   input wire logic [5:0]              filt_nibble,
   input wire logic                    filt_valid,
   input wire gcc_pkg::gcc_tx_att_t    transmit_attenuator,
   input wire logic [5:0]              rx_gain_code,
   input wire logic [5:0]              tx_gain_code
);
   // ---------------------------------
   // Checks
   // ---------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_rst_codes;
      $rose(rst_n) |-> rx_gain_code == 6'h00 && tx_gain_code == 6'h00;
   endproperty
   a_rst_codes: assert property (p_rst_codes) else $error("codes not minimum");

   property p_rx_max;
      rx_gain_code <= 6'h3c;
   endproperty
   a_rx_max: assert property (p_rx_max) else $error("rx code out of range");

   property p_oe_rel;
      serial_in.sen_n ##1 serial_in.sen_n |-> !sdio_oe;
   endproperty
   a_oe_rel: assert property (p_oe_rel) else $error("sdio driven idle");

   property p_tx_map;
      $stable(tx_gain_code) |-> (transmit_attenuator.line_amp_en ?
         (transmit_attenuator.line_att == ((tx_gain_code > 6'h27) ? 6'h27 : tx_gain_code)
          && transmit_attenuator.conv_att == 4'h0) :
         (transmit_attenuator.conv_att == tx_gain_code[3:0]
          && transmit_attenuator.line_att == 6'h00));
   endproperty
   a_tx_map: assert property (p_tx_map) else $error("tx attenuation wrong");

   property p_tx_src;
      $changed(tx_gain_code) |-> !$past(serial_in.sen_n) || tx_gain_code == $past(gain_port_bus);
   endproperty
   a_tx_src: assert property (p_tx_src) else $error("tx code bad source");

   property p_rx_half;
      $changed(rx_gain_code) && $past(serial_in.sen_n) && !$past(mode_full_duplex)
         |-> rx_gain_code == $past(gain_port_bus) || rx_gain_code[2:0] == 3'h0;
   endproperty
   a_rx_half: assert property (p_rx_half) else $error("rx load in half duplex");

   property p_filt_data;
      filt_valid |-> filt_nibble == $past(tx_nibble) && !$past(gain_strobe);
   endproperty
   a_filt_data: assert property (p_filt_data) else $error("filter nibble wrong");

   property p_filt_once;
      filt_valid |=> !filt_valid;
   endproperty
   a_filt_once: assert property (p_filt_once) else $error("filter valid long");
endmodule : gcc_gain_ctrl_checker

bind gcc_gain_ctrl gcc_gain_ctrl_checker u_chk (
   .clk(clk), .rst_n(rst_n), .mode_full_duplex(mode_full_duplex),
   .serial_in(serial_in), .sdio_oe(sdio_oe), .gain_port_bus(gain_port_bus),
   .gain_strobe(gain_strobe), .tx_nibble(tx_nibble), .filt_nibble(filt_nibble),
   .filt_valid(filt_valid), .transmit_attenuator(transmit_attenuator),
   .rx_gain_code(rx_gain_code), .tx_gain_code(tx_gain_code)
);

// ===== test/gcc_asic_model.sv
// Baseband model driving the gain port and the transmit nibble bus
`timescale 1ns/1ns
module gcc_asic_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       nibble_clock_out,
   input  wire logic       cmd_gain,
   input  wire logic [5:0] cmd_code,
   input  wire logic [5:0] cmd_port,
   output logic            gain_strobe,
   output logic            tx_word_sync,
   output logic [5:0]      tx_nibble,
   output logic [5:0]      gain_port_bus
);
   logic nclk_q;

   always @(posedge clk)
   begin
      nclk_q <= nibble_clock_out;
      gain_port_bus <= cmd_port;
      tx_nibble <= cmd_code;
      gain_strobe <= rst_n && cmd_gain;
      if (!rst_n || cmd_gain)
         tx_word_sync <= 1'b0;
      else if (nibble_clock_out && !nclk_q)
         tx_word_sync <= !tx_word_sync;
   end
endmodule : gcc_asic_model

// ===== test/tb.sv
// Self-checking bench for the gain-code control block
`timescale 1ns/1ns
module tb;
   logic                    clk = 1'b0;
   logic                    rst_n = 1'b0;
   logic                    mode_fd = 1'b1;
   logic                    cfg = 1'b0;
   logic                    nib_fall = 1'b0;
   gcc_pkg::gcc_serial_in_t ser = 3'b100;
   logic                    cmd_gain = 1'b0;
   logic [5:0]              cmd_code = 6'h00;
   logic [5:0]              cmd_port = 6'h00;
   logic                    strobe, sync, nclk, sdio_out, filt_valid;
   logic                    oe, oe_rd;
   gcc_pkg::gcc_rx_stages_t amp;
   logic [5:0]              nib, port, filt_nib, rx_code, tx_code;
   gcc_pkg::gcc_tx_att_t    att;
   logic [7:0]              rd;
   int                      err_total = 0;
   int                      n_checks = 0;

   always #4 clk = ~clk;

   gcc_gain_ctrl #(.NIB_HALF(2)) u_dut (
      .clk(clk), .rst_n(rst_n), .mode_full_duplex(mode_fd), .config_pin(cfg),
      .nib_clk_falling(nib_fall), .serial_in(ser), .sdio_out(sdio_out), .sdio_oe(oe),
      .gain_port_bus(port), .gain_strobe(strobe), .tx_word_sync(sync), .tx_nibble(nib),
      .nibble_clock_out(nclk), .filt_nibble(filt_nib), .filt_valid(filt_valid),
      .receive_gain_amp(amp), .transmit_attenuator(att), .rx_gain_code(rx_code),
      .tx_gain_code(tx_code)
   );

   gcc_asic_model u_asic (
      .clk(clk), .rst_n(rst_n), .nibble_clock_out(nclk), .cmd_gain(cmd_gain),
      .cmd_code(cmd_code), .cmd_port(cmd_port), .gain_strobe(strobe),
      .tx_word_sync(sync), .tx_nibble(nib), .gain_port_bus(port)
   );

   // ---------------------------------
   // Tasks
   // ---------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic spi(input logic [15:0] frm, output logic [7:0] dat);
      dat = 8'h00;
      ser.sen_n <= 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         ser.sclk <= 1'b0;
         ser.sdio_in <= frm[15 - i];
         repeat (2) @(posedge clk);
         ser.sclk <= 1'b1;
         repeat (2) @(posedge clk);
         if (i == 8)
            oe_rd = oe;
         if (i >= 8)
            dat[15 - i] = sdio_out;
      end
      ser.sen_n <= 1'b1;
      ser.sclk <= 1'b0;
      repeat (15) @(posedge clk);
   endtask : spi

   task automatic wait_sig(input logic [5:0] exp, input logic on_filt);
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while ((on_filt ? filt_valid !== 1'b1 : rx_code !== exp) && n < 200);
      chk({2'b00, on_filt ? filt_nib : rx_code}, {2'b00, exp});
      if (n == 200)
      begin
         err_total++;
         stop_test();
      end
      @(posedge clk);
   endtask : wait_sig

   // ---------------------------------
   // Sequence
   // ---------------------------------
   initial
   begin
      repeat (100000) @(posedge clk);
      err_total++;
      stop_test();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk({2'b00, rx_code}, 8'h00);
      chk({2'b00, tx_code}, 8'h00);
      chk({7'h00, att.line_amp_en}, 8'h01);
      spi({1'b1, 7'h0b, 8'h00}, rd);
      chk(rd, 8'h04);
      chk({7'h00, oe_rd}, 8'h01);
      spi({1'b1, 7'h10, 8'h00}, rd);
      chk(rd, 8'h00);
      $display("test reset done");
      spi({1'b0, 7'h09, 8'h45}, rd);
      chk({2'b00, rx_code}, 8'h05);
      chk({7'h00, oe_rd}, 8'h00);
      chk({1'b0, amp}, 8'h05);
      spi({1'b1, 7'h09, 8'h00}, rd);
      chk(rd, 8'h45);
      spi({1'b0, 7'h09, 8'h3a}, rd);
      chk({2'b00, rx_code}, 8'h05);
      spi({1'b1, 7'h09, 8'h00}, rd);
      chk(rd, 8'h00);
      spi({1'b0, 7'h0a, 8'h4a}, rd);
      chk({2'b00, att.line_att}, 8'h0a);
      spi({1'b0, 7'h0e, 8'h01}, rd);
      spi({1'b0, 7'h0a, 8'h5a}, rd);
      chk({4'h0, att.conv_att}, 8'h0a);
      spi({1'b1, 7'h0a, 8'h00}, rd);
      chk(rd, 8'h5a);
      spi({1'b0, 7'h09, 8'h7f}, rd);
      chk({2'b00, rx_code}, 8'h3c);
      chk({1'b0, amp}, 8'h50);
      $display("test serial done");
      cmd_code <= 6'h21;
      cmd_gain <= 1'b1;
      wait_sig(6'h21, 1'b0);
      spi({1'b1, 7'h09, 8'h00}, rd);
      chk({2'b00, rd[5:0]}, 8'h21);
      chk({1'b0, amp}, 8'h2b);
      nib_fall <= 1'b1;
      cmd_code <= 6'h2e;
      wait_sig(6'h2e, 1'b0);
      cmd_gain <= 1'b0;
      cmd_code <= 6'h13;
      repeat (10) @(posedge clk);
      wait_sig(6'h13, 1'b1);
      chk({2'b00, rx_code}, 8'h2e);
      spi({1'b0, 7'h0b, 8'h0c}, rd);
      cmd_code <= 6'h22;
      wait_sig(6'h22, 1'b0);
      spi({1'b0, 7'h0b, 8'h08}, rd);
      cmd_code <= 6'h31;
      repeat (40) @(posedge clk);
      chk({2'b00, rx_code}, 8'h22);
      mode_fd <= 1'b0;
      spi({1'b0, 7'h0b, 8'h0c}, rd);
      cmd_code <= 6'h33;
      cmd_gain <= 1'b1;
      repeat (40) @(posedge clk);
      chk({2'b00, rx_code}, 8'h22);
      cmd_gain <= 1'b0;
      $display("test nibble done");
      cmd_port <= 6'h17;
      spi({1'b0, 7'h0b, 8'h20}, rd);
      chk({2'b00, rx_code}, 8'h17);
      cmd_port <= 6'h19;
      repeat (3) @(posedge clk);
      chk({2'b00, rx_code}, 8'h19);
      spi({1'b0, 7'h0b, 8'h00}, rd);
      spi({1'b0, 7'h0b, 8'h40}, rd);
      chk({2'b00, tx_code}, 8'h19);
      cmd_port <= 6'h05;
      repeat (3) @(posedge clk);
      chk({2'b00, tx_code}, 8'h05);
      chk({2'b00, rx_code}, 8'h19);
      spi({1'b0, 7'h0b, 8'h22}, rd);
      for (int k = 0; k < 8; k++)
      begin
         cmd_port <= {k[2:0], 3'h5};
         repeat (3) @(posedge clk);
         chk({2'b00, rx_code}, (k < 2) ? 8'h00 : 8'(8 * (k - 1)));
      end
      $display("test port done");
      stop_test();
   end
endmodule : tb
